// ===== fpm_pkg.sv
package fpm_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] FPM_IDX_FLASH_CTRL_SHADOW = 12'hfd0;
    localparam logic [11:0] FPM_IDX_FLASH_CTRL_COMMIT = 12'hfd1;
    localparam logic [11:0] FPM_IDX_FLASH_CTRL_MONITOR = 12'hfd1;
    localparam logic [11:0] FPM_IDX_FLASH_STANDBY = 12'hfd2;
    localparam logic [11:0] FPM_IDX_PORT_INPUT_CTRL = 12'hfd3;
    localparam logic [11:0] FPM_IDX_SYSTEM_MAP_CTRL = 12'hfd4;
    localparam logic [11:0] FPM_IDX_SYSTEM_MAP_COMMIT = 12'hfd5;
    localparam int FPM_ADDR_W = 14;

    // ------------------------------------------------------------
    // Keys, codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FPM_COMMIT_KEY = 8'hd5;
    localparam logic [7:0] FPM_SYS_COMMIT_KEY = 8'hd4;
    localparam logic [2:0] FPM_PROG_ENABLE = 3'h5;
    localparam logic [2:0] FPM_PROG_DISABLE = 3'h2;
    localparam logic [1:0] FPM_WIN_STANDARD = 2'h0;
    localparam logic [1:0] FPM_WIN_CODE_MAP = 2'h2;
    localparam logic [1:0] FPM_RESP_OKAY = 2'h0;
    localparam logic [1:0] FPM_RESP_DECERR = 2'h3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FPM_FLD_PROG_LO = 5;
    localparam int FPM_FLD_LOADER = 4;
    localparam int FPM_FLD_WIN_LO = 2;
    localparam int FPM_FLD_REMAP = 0;
    localparam int FPM_FLD_VECTOR = 1;
    localparam int FPM_FLD_STANDBY = 0;
    localparam int FPM_FLD_OTHER_IN = 0;
    localparam int FPM_FLD_SCLK_IN = 1;
    localparam int FPM_FLD_PIC_TOP = 7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] prog_code;
        logic loader_rom_show;
        logic [1:0] window_sel;
    } fpm_flash_ctrl_t;

    localparam fpm_flash_ctrl_t FPM_FLASH_CTRL_RST = '{FPM_PROG_DISABLE, 1'b0, FPM_WIN_STANDARD};

    typedef struct packed {
        logic vector_location;
        logic ram_code_remap;
    } fpm_sys_map_t;

    typedef struct packed {
        logic code_window_in_data;
        logic loader_rom_low;
        logic loader_rom_code_high;
        logic ram_in_code;
        logic other_port_input_en;
        logic serial_clock_input_en;
    } fpm_map_t;

    typedef enum logic [1:0] {
        FPM_AXI_IDLE = 2'b00,
        FPM_AXI_RESP = 2'b01
    } fpm_resp_state_t;

endpackage : fpm_pkg

// ===== fpm_flash_protect_map.sv
// Behaviour
// - Enable needs enable code then commit key
// - Disabled: drop flash commands and toggle reads
// - Reset loads the disable code
// - Disable blocks new writes, never aborts
// - Code-map select maps code window into data
// - Standard select restores standard mapping
// - Flash commands only through data window
// - Both windows share cells; write one
// - MCU: committed remap bit maps RAM
// - Serial PROM: RAM always in code
// - MCU: committed show bit overlays loader ROM
// - Serial PROM: ROM fixed, show bit 1
// - Standby write accepted only from RAM
// - Flash access during standby gives reset
// - Flash vector: interrupt clears standby
// - RAM vector: standby kept on interrupt
// - Serial PROM: port inputs off after reset
// - Enable bits open sclk and other inputs
// - MCU: port input control has no effect
// - Commit key copies shadow to active
// - Monitor flag only when enable committed
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fpm_flash_protect_map (
    input wire logic aclk, // System clock, 125 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [fpm_pkg::FPM_ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [fpm_pkg::FPM_ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic serial_prom_mode_pin, // Boot mode pin, 1 = serial PROM
    input wire logic cpu_fetch_from_ram, // Current instruction came from RAM
    input wire logic cpu_flash_access, // CPU fetch, read or write hits flash
    input wire logic cpu_irq_entry, // Pulse: interrupt vector fetch begins
    input wire logic cpu_cmd_wr, // CPU command write cycle to flash
    input wire logic [15:0] cpu_cmd_addr, // Data-space address of that cycle
    input wire logic cpu_toggle_rd, // CPU toggle status read
    output logic flash_cmd_wr, // Command write passed to sequencer
    output logic flash_toggle_rd, // Toggle read passed to flash
    output logic flash_standby_reset, // Pulse: flash standby reset request
    output logic flash_standby, // Flash standby level
    output fpm_pkg::fpm_map_t map // Memory map and port input enables
);
    import fpm_pkg::*;

    // ------------------------------------------------------------
    // Mode pin synchroniser
    // ------------------------------------------------------------
    logic mode_meta_reg;
    logic serial_mode_reg;

    // Not reset, so the mode is settled at release and serial inputs never open briefly
    always_ff @(posedge aclk) begin
        mode_meta_reg <= serial_prom_mode_pin;
        serial_mode_reg <= mode_meta_reg;
    end

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic aw_full_reg;
    logic w_full_reg;
    logic [FPM_ADDR_W-1:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic w_lane_reg;
    logic wr_fire;
    logic [11:0] wr_idx;
    logic wr_ok;
    logic wr_hit;

    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    // Register writes wait for the previous response to drain
    assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_idx = aw_addr_reg[FPM_ADDR_W-1:2];
    assign wr_ok = wr_fire && w_lane_reg;
    always_comb begin
        case (wr_idx)
            FPM_IDX_FLASH_CTRL_SHADOW,
            FPM_IDX_FLASH_CTRL_COMMIT,
            FPM_IDX_FLASH_STANDBY,
            FPM_IDX_PORT_INPUT_CTRL,
            FPM_IDX_SYSTEM_MAP_CTRL,
            FPM_IDX_SYSTEM_MAP_COMMIT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_lane_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= FPM_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? FPM_RESP_OKAY : FPM_RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shadow and active flash control
    // ------------------------------------------------------------
    fpm_flash_ctrl_t shadow_reg;
    fpm_flash_ctrl_t active_reg;
    logic commit_wr;
    logic commit_key_wr;
    assign commit_wr = wr_ok && (wr_idx == FPM_IDX_FLASH_CTRL_COMMIT);
    assign commit_key_wr = commit_wr && (w_data_reg == FPM_COMMIT_KEY);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shadow_reg <= FPM_FLASH_CTRL_RST;
        end else if (wr_ok && wr_idx == FPM_IDX_FLASH_CTRL_SHADOW) begin
            shadow_reg.prog_code <= w_data_reg[FPM_FLD_PROG_LO+:3];
            shadow_reg.window_sel <= w_data_reg[FPM_FLD_WIN_LO+:2];
            // Serial PROM: show bit ignores writes
            if (!serial_mode_reg) begin
                shadow_reg.loader_rom_show <= w_data_reg[FPM_FLD_LOADER];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_reg <= FPM_FLASH_CTRL_RST;
        end else if (commit_key_wr) begin
            active_reg <= shadow_reg;
        end
    end

    logic prog_en_active;
    logic loader_show_eff;
    assign prog_en_active = (active_reg.prog_code == FPM_PROG_ENABLE);
    assign loader_show_eff = serial_mode_reg || active_reg.loader_rom_show;

    // ------------------------------------------------------------
    // System map control
    // ------------------------------------------------------------
    fpm_sys_map_t sys_shadow_reg;
    fpm_sys_map_t sys_active_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_shadow_reg <= '0;
        end else if (wr_ok && wr_idx == FPM_IDX_SYSTEM_MAP_CTRL) begin
            sys_shadow_reg.vector_location <= w_data_reg[FPM_FLD_VECTOR];
            sys_shadow_reg.ram_code_remap <= w_data_reg[FPM_FLD_REMAP];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_active_reg <= '0;
        end else if (wr_ok && wr_idx == FPM_IDX_SYSTEM_MAP_COMMIT
                     && w_data_reg == FPM_SYS_COMMIT_KEY) begin
            sys_active_reg <= sys_shadow_reg;
        end
    end

    // ------------------------------------------------------------
    // Flash standby
    // ------------------------------------------------------------
    logic standby_reg;
    logic standby_wr;

    assign standby_wr = wr_ok && (wr_idx == FPM_IDX_FLASH_STANDBY);

    // RAM vector keeps
    // Interrupt clear wins so the flash vector fetch is always safe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_reg <= 1'b0;
        end else if (cpu_irq_entry && !sys_active_reg.vector_location) begin
            standby_reg <= 1'b0;
        end else if (standby_wr && cpu_fetch_from_ram) begin
            standby_reg <= w_data_reg[FPM_FLD_STANDBY];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_standby_reset <= 1'b0;
        end else begin
            flash_standby_reset <= cpu_flash_access && standby_reg;
        end
    end

    assign flash_standby = standby_reg;

    // ------------------------------------------------------------
    // Port input control
    // ------------------------------------------------------------
    logic other_in_reg;
    logic sclk_in_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            other_in_reg <= 1'b0;
            sclk_in_reg <= 1'b0;
        end else if (wr_ok && wr_idx == FPM_IDX_PORT_INPUT_CTRL && serial_mode_reg) begin
            other_in_reg <= w_data_reg[FPM_FLD_OTHER_IN];
            sclk_in_reg <= w_data_reg[FPM_FLD_SCLK_IN];
        end
    end

    // ------------------------------------------------------------
    // Command gating and map outputs
    // ------------------------------------------------------------
    // one shared window
    // data window only
    // Disabling never resets the sequencer; only new cycles are dropped
    assign flash_cmd_wr = cpu_cmd_wr && prog_en_active && cpu_cmd_addr[15];
    assign flash_toggle_rd = cpu_toggle_rd && prog_en_active;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            map <= '0;
        end else begin
            map.code_window_in_data <= (active_reg.window_sel == FPM_WIN_CODE_MAP);
            map.loader_rom_low <= loader_show_eff;
            map.loader_rom_code_high <= serial_mode_reg;
            map.ram_in_code <= serial_mode_reg || sys_active_reg.ram_code_remap;
            map.other_port_input_en <= !serial_mode_reg || other_in_reg;
            map.serial_clock_input_en <= !serial_mode_reg || sclk_in_reg;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    logic [11:0] rd_idx;
    logic [7:0] rd_byte;
    logic rd_hit;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx = s_axi_araddr[FPM_ADDR_W-1:2];
    always_comb begin
        rd_byte = '0;
        rd_hit = 1'b1;
        case (rd_idx)
            FPM_IDX_FLASH_CTRL_SHADOW: begin
                rd_byte[FPM_FLD_PROG_LO+:3] = shadow_reg.prog_code;
                rd_byte[FPM_FLD_LOADER] = serial_mode_reg || shadow_reg.loader_rom_show;
                rd_byte[FPM_FLD_WIN_LO+:2] = shadow_reg.window_sel;
            end
            FPM_IDX_FLASH_CTRL_MONITOR: begin
                rd_byte[FPM_FLD_PROG_LO] = prog_en_active;
                rd_byte[FPM_FLD_LOADER] = loader_show_eff;
                rd_byte[FPM_FLD_WIN_LO+:2] = active_reg.window_sel;
            end
            FPM_IDX_FLASH_STANDBY, FPM_IDX_SYSTEM_MAP_COMMIT: rd_byte = '0;
            FPM_IDX_PORT_INPUT_CTRL: begin
                if (serial_mode_reg) begin
                    rd_byte[FPM_FLD_PIC_TOP] = 1'b1;
                    rd_byte[FPM_FLD_SCLK_IN] = sclk_in_reg;
                    rd_byte[FPM_FLD_OTHER_IN] = other_in_reg;
                end
            end
            FPM_IDX_SYSTEM_MAP_CTRL: begin
                rd_byte[FPM_FLD_VECTOR] = sys_shadow_reg.vector_location;
                rd_byte[FPM_FLD_REMAP] = sys_shadow_reg.ram_code_remap;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= FPM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? FPM_RESP_OKAY : FPM_RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_load_enable;
        wr_ok && wr_idx == FPM_IDX_FLASH_CTRL_SHADOW
            && w_data_reg[FPM_FLD_PROG_LO+:3] == FPM_PROG_ENABLE;
    endsequence
    sequence s_commit;
        commit_key_wr;
    endsequence
    a_enable_needs_commit: assert property (
        s_load_enable ##0 !prog_en_active |=> !prog_en_active)
        else $error("Program enable took effect without commit");
    a_cmd_blocked: assert property (
        active_reg.prog_code != FPM_PROG_ENABLE |-> !flash_cmd_wr && !flash_toggle_rd)
        else $error("Flash command passed while disabled");
    a_reset_disables: assert property (
        $rose(aresetn) |-> !prog_en_active && active_reg.prog_code == FPM_PROG_DISABLE)
        else $error("Program enable not disabled after reset");
    a_commit_copies: assert property (
        s_commit |=> active_reg == $past(shadow_reg))
        else $error("Commit did not copy shadow");
    a_bad_key_ignored: assert property (
        commit_wr && w_data_reg != FPM_COMMIT_KEY |=> $stable(active_reg))
        else $error("Active settings changed on wrong key");
    a_code_window_map: assert property (
        active_reg.window_sel == FPM_WIN_CODE_MAP ##1 $stable(active_reg)
            |-> map.code_window_in_data)
        else $error("Code window not mapped into data");
    // Three cycles of mode so the map still cleared by reset is never judged
    a_ram_serial: assert property (
        serial_mode_reg ##1 serial_mode_reg ##1 serial_mode_reg
            |-> map.ram_in_code && map.loader_rom_code_high)
        else $error("Serial PROM map wrong");
    a_standby_reset: assert property (
        cpu_flash_access && standby_reg |=> flash_standby_reset)
        else $error("Standby reset missing");
    a_irq_clears: assert property (
        cpu_irq_entry && !sys_active_reg.vector_location |=> !standby_reg)
        else $error("Standby not cleared on flash vector");
    a_flash_code_write: assert property (
        standby_wr && !cpu_fetch_from_ram && !cpu_irq_entry |=> $stable(standby_reg))
        else $error("Standby written from flash code");
    a_mcu_ports_open: assert property (
        !serial_mode_reg ##1 !serial_mode_reg ##1 !serial_mode_reg
            |-> map.other_port_input_en && map.serial_clock_input_en)
        else $error("Port inputs gated in MCU mode");
endmodule : fpm_flash_protect_map
`default_nettype wire

// ===== fpm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpm_cpu_model (
    input wire logic aclk, // System clock
    input wire logic flash_cmd_wr, // Command write seen by sequencer
    input wire logic flash_toggle_rd, // Toggle read seen by flash
    output logic fetch_ram, // Instruction came from RAM
    output logic flash_acc, // Flash fetch, read or write
    output logic irq, // Vector fetch pulse
    output logic cmd_wr, // Command write cycle
    output logic toggle_rd, // Toggle status read
    output logic [15:0] cmd_addr // Data-space address
);
    initial begin
        {fetch_ram, flash_acc, irq, cmd_wr, toggle_rd} = 5'h0;
        cmd_addr = 16'h0;
    end
    task ram_src(input logic v);
        @(posedge aclk);
        fetch_ram <= v;
        @(negedge aclk);
    endtask : ram_src
    // single bus cycle
    // Each cycle completes before the next, so no sequence is left open and
    // no cell is written twice or through both windows
    task cyc(input logic c, t, f, i, input logic [15:0] a, output logic oc, ot);
        @(posedge aclk);
        {cmd_wr, toggle_rd, flash_acc, irq} <= {c, t, f, i};
        cmd_addr <= a;
        @(negedge aclk);
        oc = flash_cmd_wr;
        ot = flash_toggle_rd;
        @(posedge aclk);
        {cmd_wr, toggle_rd, flash_acc, irq} <= 4'h0;
        @(negedge aclk);
    endtask : cyc
endmodule : fpm_cpu_model
`default_nettype wire

// ===== fpm_flash_protect_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fpm_flash_protect_map_tb;
    import fpm_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [13:0] awaddr = 14'h0;
    logic [13:0] araddr = 14'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic mode = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, ram, facc, irq, cwr, trd, fcw, ftr, sbr, sb;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, v;
    logic [15:0] caddr;
    logic oc, ot;
    fpm_map_t map;
    int error_cnt = 0;
    int cmp_count = 0;
    always #4 aclk = ~aclk;
    fpm_flash_protect_map dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_prom_mode_pin(mode), .cpu_fetch_from_ram(ram), .cpu_flash_access(facc),
        .cpu_irq_entry(irq), .cpu_cmd_wr(cwr), .cpu_cmd_addr(caddr), .cpu_toggle_rd(trd),
        .flash_cmd_wr(fcw), .flash_toggle_rd(ftr), .flash_standby_reset(sbr),
        .flash_standby(sb), .map(map));
    fpm_cpu_model cpu (.aclk(aclk), .flash_cmd_wr(fcw), .flash_toggle_rd(ftr),
        .fetch_ram(ram), .flash_acc(facc), .irq(irq), .cmd_wr(cwr), .toggle_rd(trd),
        .cmd_addr(caddr));
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Ready is looked at on the falling edge, where it is settled for the
    // rising edge that completes the transfer
    task wr(input logic [13:0] a, input logic [7:0] d);
        logic ta, tw, dn;
        dn = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= 3'h7;
        while (!dn) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            dn = bvalid & bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (dn) bready <= 1'h0;
        end
        @(negedge aclk);
    endtask : wr
    task rd(input logic [13:0] a);
        logic ta, dn;
        dn = 1'h0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        while (!dn) begin
            @(negedge aclk);
            ta = arvalid & arready;
            dn = rvalid & rready;
            v = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'h0;
            if (dn) rready <= 1'h0;
        end
        @(negedge aclk);
    endtask : rd
    task rdc(input logic [13:0] a, input logic [31:0] e);
        rd(a);
        chk(v, e);
    endtask : rdc
    task cmd(input logic [15:0] a, input logic ec, et);
        cpu.cyc(1'h1, 1'h1, 1'h0, 1'h0, a, oc, ot);
        chk(oc, ec);
        chk(ot, et);
    endtask : cmd
    task rst(input logic m);
        @(posedge aclk);
        aresetn <= 1'h0;
        mode <= m;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(negedge aclk);
    endtask : rst
    task done(input string s);
        $display("test %s done", s);
    endtask : done
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
    initial begin
        rst(1'h0);
        rdc(14'h3f40, 32'h40);
        rdc(14'h3f44, 32'h0);
        cmd(16'h8555, 1'h0, 1'h0);
        wr(14'h3f4c, 8'h03);
        chk({map.other_port_input_en, map.serial_clock_input_en}, 2'h3);
        rdc(14'h3f4c, 32'h0);
        rd(14'h0000);
        chk(r, FPM_RESP_DECERR);
        done("reset");
        wr(14'h3f40, 8'ha8);
        rdc(14'h3f44, 32'h0);
        wr(14'h3f44, 8'h12);
        rdc(14'h3f44, 32'h0);
        cmd(16'h8555, 1'h0, 1'h0);
        wr(14'h3f44, 8'hd5);
        chk(r, FPM_RESP_OKAY);
        rdc(14'h3f44, 32'h28);
        chk(map.code_window_in_data, 1'h1);
        cmd(16'h8555, 1'h1, 1'h1);
        cmd(16'h1555, 1'h0, 1'h1);
        done("enable");
        wr(14'h3f40, 8'h50);
        wr(14'h3f44, 8'hd5);
        cmd(16'hf555, 1'h0, 1'h0);
        chk(map.code_window_in_data, 1'h0);
        chk(map.loader_rom_low, 1'h1);
        wr(14'h3f40, 8'h40);
        wr(14'h3f44, 8'hd5);
        chk(map.loader_rom_low, 1'h0);
        done("protect");
        wr(14'h3f50, 8'h01);
        chk(map.ram_in_code, 1'h0);
        wr(14'h3f54, 8'hd4);
        chk(map.ram_in_code, 1'h1);
        wr(14'h3f50, 8'h00);
        wr(14'h3f54, 8'hd4);
        chk(map.ram_in_code, 1'h0);
        done("remap");
        wr(14'h3f48, 8'h01);
        chk(sb, 1'h0);
        cpu.ram_src(1'h1);
        wr(14'h3f48, 8'h01);
        chk(sb, 1'h1);
        cpu.cyc(1'h0, 1'h0, 1'h1, 1'h0, 16'h0, oc, ot);
        chk(sbr, 1'h1);
        cpu.cyc(1'h0, 1'h0, 1'h0, 1'h1, 16'h0, oc, ot);
        chk(sb, 1'h0);
        wr(14'h3f50, 8'h02);
        wr(14'h3f54, 8'hd4);
        wr(14'h3f48, 8'h01);
        cpu.cyc(1'h0, 1'h0, 1'h0, 1'h1, 16'h0, oc, ot);
        chk(sb, 1'h1);
        wr(14'h3f48, 8'h00);
        cpu.ram_src(1'h0);
        done("standby");
        rst(1'h1);
        chk({map.other_port_input_en, map.serial_clock_input_en}, 2'h0);
        chk(map.ram_in_code, 1'h1);
        chk({map.loader_rom_low, map.loader_rom_code_high}, 2'h3);
        wr(14'h3f40, 8'h40);
        rdc(14'h3f40, 32'h50);
        wr(14'h3f4c, 8'h02);
        chk({map.other_port_input_en, map.serial_clock_input_en}, 2'h1);
        rdc(14'h3f4c, 32'h82);
        wr(14'h3f4c, 8'h01);
        chk({map.other_port_input_en, map.serial_clock_input_en}, 2'h2);
        done("serial");
        end_sim();
    end
endmodule : fpm_flash_protect_map_tb
`default_nettype wire
